// [bench/drc_mem_model.sv]
/*
 * Model of four 4096 x 1 dynamic memories sharing one cycle strobe.
 * Assumes the strobe, selects and address come from a clocked controller.
 */
`timescale 1ns/1ps
module drc_mem_model #(
	parameter int NDEV = 4,
	parameter int REF_NS = 81920
) (
	input wire logic mclk_in,
	input wire logic ce_in,
	input wire logic [NDEV-1:0] cs_n_in,
	input wire logic we_n_in,
	input wire logic [11:0] addr_in,
	input wire logic din_in,
	output logic dout_out,
	output logic [7:0] viol_cnt_out
);
	logic mem [NDEV][4096];
	logic [11:0] addr_q;
	logic [NDEV-1:0] sel_q;
	logic rd_q = 1'b0;
	logic out_en = 1'b0;
	logic rd_bit = 1'b0;
	logic pend = 1'b0;
	logic pend_v = 1'b0;
	realtime t_ce = 0.0;
	realtime last_ref [64];
	initial begin
		viol_cnt_out = 8'h00;
		foreach (last_ref[i]) last_ref[i] = 0.0;
	end
	// a released line shows the inverse bit, so a stale sample cannot pass
	assign dout_out = out_en ? rd_bit : ~rd_bit;
	always @(posedge ce_in) begin
		addr_q = addr_in;
		sel_q = ~cs_n_in;
		rd_q = we_n_in;
		t_ce = $realtime;
		if ($realtime - last_ref[addr_in[5:0]] > REF_NS) viol_cnt_out++;
		last_ref[addr_in[5:0]] = $realtime;
		if ($countones(sel_q) > 1) viol_cnt_out++;
		#(drc_pkg::T_CO_NS - 1);
		for (int i = 0; i < NDEV; i++) if (sel_q[i]) rd_bit = mem[i][addr_q];
		out_en = ce_in && rd_q && (sel_q != '0);
	end
	always @(addr_in or cs_n_in) begin
		if (ce_in && $realtime - t_ce < drc_pkg::T_AH_NS) viol_cnt_out++;
	end
	always @(negedge we_n_in) begin
		if (ce_in && rd_q && $realtime - t_ce < drc_pkg::T_CO_NS) viol_cnt_out++;
	end
	always @(posedge mclk_in) begin
		if (ce_in && !we_n_in) begin
			pend = din_in;
			pend_v = 1'b1;
		end
	end
	always @(negedge ce_in) begin
		out_en = 1'b0;
		for (int i = 0; i < NDEV; i++) if (sel_q[i] && pend_v) mem[i][addr_q] = pend;
		pend_v = 1'b0;
	end
endmodule : drc_mem_model

// [bench/test_dynamic_ram_4k_by_1.sv]
/*
 * Self-checking bench of the memory host with a shadow copy of the bank.
 * Assumes the model answers on the shared data-out line.
 */
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module test_dynamic_ram_4k_by_1;
	logic mclk, arst_n, req_valid, req_wdata, dout;
	logic [1:0] req_op;
	logic [13:0] req_addr;
	logic req_ready_out, rsp_valid_out, rsp_rdata_out, ce_out, we_n_out, din_out;
	logic [3:0] cs_n_out;
	logic [11:0] address_lines_out;
	logic [7:0] viol_cnt;
	logic shadow [16384];
	logic [13:0] addrs [16];
	logic [1:0] exp_q [$];
	logic [1:0] e;
	logic [5:0] row = 6'h00;
	logic ce_prev = 1'b0;
	int error_cnt = 0;
	int comparisons = 0;
	int refreshes = 0;
	integer seed = 32'h6ab1134a;
	drc_host #(.DEV_W(2), .REF_PERIOD_CYC(8192)) uut (.mclk_in(mclk), .arst_n_in(arst_n),
		.req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr),
		.req_wdata_in(req_wdata), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_rdata_out(rsp_rdata_out), .ce_out(ce_out), .cs_n_out(cs_n_out),
		.we_n_out(we_n_out), .address_lines_out(address_lines_out), .din_out(din_out),
		.dout_in(dout));
	drc_mem_model #(.NDEV(4), .REF_NS(81920)) mem_model (.mclk_in(mclk), .ce_in(ce_out),
		.cs_n_in(cs_n_out), .we_n_in(we_n_out), .addr_in(address_lines_out), .din_in(din_out),
		.dout_out(dout), .viol_cnt_out(viol_cnt));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic end_of_test;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic do_op(input logic [1:0] op, input logic [13:0] a, input logic d);
		int n = 0;
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_wdata <= d;
		@(posedge mclk);
		while (req_ready_out !== 1'b1 && n < 500) begin
			n++;
			@(posedge mclk);
		end
		`CHK("req_ready", req_ready_out, 1'b1);
		exp_q.push_back({op != 2'h1, shadow[a]});
		if (op != 2'h0) shadow[a] = d;
		req_valid <= 1'b0;
		@(posedge mclk);
	endtask : do_op
	always @(posedge mclk) begin
		if (rsp_valid_out === 1'b1) begin
			`CHK("rsp_pending", exp_q.size() > 0, 1'b1);
			if (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				if (e[1]) `CHK("rdata", rsp_rdata_out, e[0]);
			end
		end
		if (ce_out === 1'b1 && ce_prev !== 1'b1) begin
			`CHK("one_select", $countones(~cs_n_out) <= 1, 1'b1);
			if (cs_n_out === 4'hF) begin
				`CHK("refresh_addr", address_lines_out, {6'h00, row});
				row++;
				refreshes++;
			end
		end
		ce_prev = ce_out;
	end
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_addr = 14'h0000;
		req_wdata = 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			addrs[i] = {2'(i), (i < 4) ? 12'h000 : (i < 8) ? 12'hFFF : 12'($random(seed))};
			do_op(2'h1, addrs[i], 1'($random(seed)));
		end
		$display("test write fill done");
		repeat (2) for (int i = 0; i < 16; i++) do_op(2'h0, addrs[i], 1'b0);
		$display("test repeated read done");
		for (int k = 0; k < 60; k++) begin
			do_op(2'($unsigned($random(seed)) % 3), addrs[$unsigned($random(seed)) % 16],
				1'($random(seed)));
		end
		$display("test mixed ops done");
		repeat (17000) @(posedge mclk);
		for (int i = 0; i < 16; i++) do_op(2'h0, addrs[i], 1'b0);
		repeat (100) @(posedge mclk);
		`CHK("model_violations", viol_cnt, 8'h00);
		`CHK("refresh_rows", refreshes >= 64, 1'b1);
		`CHK("rsp_left", exp_q.size(), 0);
		$display("test refresh retention done");
		end_of_test();
	end
endmodule : test_dynamic_ram_4k_by_1

// [inc/drc_pkg.sv]
/*
 * Constants, types and timing counts of the host controller for a 4096 x 1
 * dynamic memory. Assumes a single 100 MHz system clock.
 */
package drc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 12;
	localparam int ROW_W = 6;
	localparam int ROWS = 64;
	localparam int CNT_W = 6;

	// device timing in ns, fastest grade
	localparam int T_AH_NS = 100;
	localparam int T_CE_NS = 230;
	localparam int T_CO_NS = 180;
	localparam int T_CC_NS = 130;
	localparam int T_W_NS = 150;
	localparam int T_WP_NS = 50;
	localparam int T_CW_NS = 150;
	localparam int T_CRW_NS = 350;
	localparam int REF_PERIOD_MS = 2;

	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_min

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : max2

	localparam int T_AH_CYC = cyc_min(T_AH_NS);
	localparam int T_CE_CYC = cyc_min(T_CE_NS);
	localparam int T_CO_CYC = cyc_min(T_CO_NS);
	localparam int T_CC_CYC = cyc_min(T_CC_NS);
	localparam int T_WR_CYC = max2(T_CE_CYC, max2(cyc_min(T_W_NS), cyc_min(T_CW_NS)));
	localparam int T_RMW_CYC = max2(cyc_min(T_CRW_NS),
		T_CO_CYC + 1 + max2(cyc_min(T_W_NS), cyc_min(T_WP_NS)));
	// longest time: rounded down
	localparam int REF_PERIOD_CYC = REF_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	// room for one access in flight before a refresh is served
	localparam int REF_MARGIN_CYC = 128;

	typedef enum logic [1:0] {
		DRC_OP_READ = 2'h0,
		DRC_OP_WRITE = 2'h1,
		DRC_OP_RMW = 2'h2
	} drc_op_e;

	typedef enum logic [1:0] {
		DRC_ST_IDLE = 2'h0,
		DRC_ST_SETUP = 2'h1,
		DRC_ST_STROBE = 2'h3,
		DRC_ST_PRECH = 2'h2
	} drc_state_e;

	function automatic logic [CNT_W-1:0] strobe_len(input drc_op_e op);
		unique case (op)
			DRC_OP_WRITE: return CNT_W'(T_WR_CYC);
			DRC_OP_RMW: return CNT_W'(T_RMW_CYC);
			default: return CNT_W'(T_CE_CYC);
		endcase
	endfunction : strobe_len
endpackage : drc_pkg

// [inc/drc_rfsh_if.sv]
/*
 * Refresh request handshake between the scheduler and the cycle sequencer.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface drc_rfsh_if #(
	parameter int ROW_W = 6
);
	logic req;
	logic ack;
	logic [ROW_W-1:0] row;
	modport sched (output req, output row, input ack);
	modport ctrl (input req, input row, output ack);
endinterface : drc_rfsh_if

// [rtl/drc_host.sv]
/*
 * Host controller for a 4096 x 1 dynamic memory bank: one request port,
 * read, early write and read-then-write cycles, and timed refresh by read.
 * Assumes the memory pins sit behind level shifters and that the data-out
 * pin is synchronous to the clock.
 */
`timescale 1ns/1ps
module drc_host #(
	parameter int DEV_W = 2,
	parameter int REF_PERIOD_CYC = drc_pkg::REF_PERIOD_CYC
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic req_valid_in,
	input wire logic [1:0] req_op_in,
	input wire logic [drc_pkg::ADDR_W+DEV_W-1:0] req_addr_in,
	input wire logic req_wdata_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic rsp_rdata_out,
	output logic ce_out,
	output logic [(1<<DEV_W)-1:0] cs_n_out,
	output logic we_n_out,
	output logic [drc_pkg::ADDR_W-1:0] address_lines_out,
	output logic din_out,
	input wire logic dout_in
);
	localparam int NDEV = 1 << DEV_W;
	localparam int INTERVAL_CYC = (REF_PERIOD_CYC - drc_pkg::REF_MARGIN_CYC) / drc_pkg::ROWS;

	drc_rfsh_if #(.ROW_W(drc_pkg::ROW_W)) rf ();

	drc_rfsh_sched #(.INTERVAL_CYC(INTERVAL_CYC)) u_sched (
		.mclk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.rf(rf.sched)
	);

	drc_pkg::drc_state_e state_q, state_d;
	drc_pkg::drc_op_e op_q, op_d;
	logic [drc_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic refresh_q, refresh_d;
	logic ready_q, ready_d;
	logic rsp_q, rsp_d;
	logic rdata_q, rdata_d;
	logic ce_q, ce_d;
	logic [NDEV-1:0] cs_n_q, cs_n_d;
	logic we_n_q, we_n_d;
	logic [drc_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic din_q, din_d;
	logic take_user, take_rfsh;
	logic [DEV_W-1:0] dev_idx;

	assign dev_idx = req_addr_in[drc_pkg::ADDR_W +: DEV_W];
	assign take_user = (state_q == drc_pkg::DRC_ST_IDLE) && req_valid_in && ready_q;
	assign take_rfsh = (state_q == drc_pkg::DRC_ST_IDLE) && !take_user && rf.req;
	assign rf.ack = take_rfsh;

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		cnt_d = cnt_q;
		refresh_d = refresh_q;
		rsp_d = 1'b0;
		rdata_d = rdata_q;
		cs_n_d = cs_n_q;
		we_n_d = we_n_q;
		addr_d = addr_q;
		din_d = din_q;
		unique case (state_q)
			drc_pkg::DRC_ST_IDLE: begin
				if (take_user) begin
					op_d = drc_pkg::drc_op_e'(req_op_in);
					refresh_d = 1'b0;
					addr_d = req_addr_in[drc_pkg::ADDR_W-1:0];
					cs_n_d = ~(NDEV'(1) << dev_idx);
					// early write: data and write strobe settle before the strobe rises
					we_n_d = (req_op_in != drc_pkg::DRC_OP_WRITE);
					din_d = req_wdata_in;
					state_d = drc_pkg::DRC_ST_SETUP;
				end else if (take_rfsh) begin
					op_d = drc_pkg::DRC_OP_READ;
					refresh_d = 1'b1;
					// column bits held at zero so the whole address is stable
					addr_d = {{(drc_pkg::ADDR_W - drc_pkg::ROW_W){1'b0}}, rf.row};
					cs_n_d = '1;
					we_n_d = 1'b1;
					state_d = drc_pkg::DRC_ST_SETUP;
				end
			end
			drc_pkg::DRC_ST_SETUP: begin
				cnt_d = '0;
				state_d = drc_pkg::DRC_ST_STROBE;
			end
			drc_pkg::DRC_ST_STROBE: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == drc_pkg::CNT_W'(drc_pkg::T_CO_CYC) && !refresh_q) begin
					rdata_d = dout_in;
				end
				// write back only once the read data is out
				if (op_q == drc_pkg::DRC_OP_RMW && cnt_q == drc_pkg::CNT_W'(drc_pkg::T_CO_CYC)) begin
					we_n_d = 1'b0;
				end
				if (cnt_q == drc_pkg::strobe_len(op_q) - 1'b1) begin
					cnt_d = '0;
					we_n_d = 1'b1;
					cs_n_d = '1;
					rsp_d = !refresh_q;
					state_d = drc_pkg::DRC_ST_PRECH;
				end
			end
			drc_pkg::DRC_ST_PRECH: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == drc_pkg::CNT_W'(drc_pkg::T_CC_CYC - 1)) begin
					cnt_d = '0;
					state_d = drc_pkg::DRC_ST_IDLE;
				end
			end
		endcase
		ce_d = (state_d == drc_pkg::DRC_ST_STROBE);
		// stop taking work while a refresh waits, so refresh cannot starve
		ready_d = (state_d == drc_pkg::DRC_ST_IDLE) && !rf.req && !take_user;
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= drc_pkg::DRC_ST_IDLE;
			op_q <= drc_pkg::DRC_OP_READ;
			cnt_q <= '0;
			refresh_q <= 1'b0;
			ready_q <= 1'b0;
			rsp_q <= 1'b0;
			rdata_q <= 1'b0;
			ce_q <= 1'b0;
			cs_n_q <= '1;
			we_n_q <= 1'b1;
			addr_q <= '0;
			din_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			cnt_q <= cnt_d;
			refresh_q <= refresh_d;
			ready_q <= ready_d;
			rsp_q <= rsp_d;
			rdata_q <= rdata_d;
			ce_q <= ce_d;
			cs_n_q <= cs_n_d;
			we_n_q <= we_n_d;
			addr_q <= addr_d;
			din_q <= din_d;
		end
	end

	assign req_ready_out = ready_q;
	assign rsp_valid_out = rsp_q;
	assign rsp_rdata_out = rdata_q;
	assign ce_out = ce_q;
	assign cs_n_out = cs_n_q;
	assign we_n_out = we_n_q;
	assign address_lines_out = addr_q;
	assign din_out = din_q;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	AST_RFSH_IS_READ: assert property (
		refresh_q && ce_q |-> we_n_q && (&cs_n_q))
		else $error("refresh cycle is not a deselected read");

	AST_ADDR_STABLE: assert property (
		$rose(ce_q) |-> $stable(addr_q) ##1 $stable(addr_q) [*8] ##1 $stable(addr_q))
		else $error("address moved within hold interval");

	AST_EARLY_DATA: assert property (
		$rose(ce_q) && !we_n_q |-> $stable(din_q) && $past(!we_n_q))
		else $error("early write data not ready at strobe rise");

	AST_RMW_WE_HIGH: assert property (
		ce_q && op_q == drc_pkg::DRC_OP_RMW && $fell(we_n_q)
		|-> int'(cnt_q) == drc_pkg::T_CO_CYC + 1)
		else $error("write-back started before output delay");

	AST_RMW_NO_EARLY: assert property (
		$rose(ce_q) && op_q == drc_pkg::DRC_OP_RMW |-> we_n_q [*8])
		else $error("read-then-write dropped write strobe early");

	AST_ONE_SELECT: assert property (
		$onehot0(~cs_n_q))
		else $error("more than one device selected");

	AST_RFSH_ROW_LOW: assert property (
		refresh_q && ce_q |-> addr_q[drc_pkg::ADDR_W-1:drc_pkg::ROW_W] == '0)
		else $error("refresh row not on lowest address lines");

	AST_PRECHARGE: assert property (
		$fell(ce_q) |-> !ce_q [*8])
		else $error("strobe off time too short");

	AST_HOLD_SELECT: assert property (
		ce_q && $past(ce_q) |-> $stable(cs_n_q))
		else $error("device select moved inside a strobe cycle");

	AST_DATA_HELD: assert property (
		ce_q && $past(ce_q) |-> $stable(din_q))
		else $error("write data moved inside a strobe cycle");

	COV_READ: cover property ($rose(ce_q) && !refresh_q && op_q == drc_pkg::DRC_OP_READ);
	COV_WRITE: cover property ($rose(ce_q) && op_q == drc_pkg::DRC_OP_WRITE);
	COV_RMW: cover property ($fell(we_n_q) && op_q == drc_pkg::DRC_OP_RMW);
	COV_RFSH: cover property ($rose(ce_q) && refresh_q);
endmodule : drc_host

// [rtl/drc_rfsh_sched.sv]
/*
 * Refresh scheduler: a free running interval timer raises a sticky request,
 * and each acknowledge steps the row counter. Assumes the sequencer serves
 * a request within the margin reserved in the package.
 */
`timescale 1ns/1ps
module drc_rfsh_sched #(
	parameter int INTERVAL_CYC = 3123
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	drc_rfsh_if.sched rf
);
	localparam int IW = $clog2(INTERVAL_CYC + 1);

	logic [IW-1:0] tmr_q, tmr_d;
	logic req_q, req_d;
	logic [drc_pkg::ROW_W-1:0] row_q, row_d;
	logic [7:0] wait_q, wait_d;

	always_comb begin
		tmr_d = (tmr_q == '0) ? IW'(INTERVAL_CYC - 1) : tmr_q - 1'b1;
		// a new tick wins over an acknowledge in the same cycle
		req_d = (tmr_q == '0) | (req_q & ~rf.ack);
		row_d = rf.ack ? row_q + 1'b1 : row_q;
		wait_d = (req_q && !rf.ack) ? wait_q + 8'h01 : 8'h00;
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tmr_q <= '0;
			req_q <= 1'b0;
			row_q <= '0;
			wait_q <= 8'h00;
		end else begin
			tmr_q <= tmr_d;
			req_q <= req_d;
			row_q <= row_d;
			wait_q <= wait_d;
		end
	end

	assign rf.req = req_q;
	assign rf.row = row_q;

	AST_RFSH_SERVED: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		int'(wait_q) < drc_pkg::REF_MARGIN_CYC)
		else $error("refresh request waited too long");
endmodule : drc_rfsh_sched
